// File: ioexp_pkg.sv
// Purpose: Shared constants for the serial I/O expander core
// Assumes: Two 8-line ports, byte-wide registers, 7-bit target address
// Notes: Command codes select one of eight registers
package ioexp_pkg;
   localparam int PORT_W = 8;
   localparam logic [6:0] TARGET_BASE = 7'h20;  // Low bit replaced by address-select pin
   localparam logic [2:0] CMD_IN0 = 3'h0;
   localparam logic [2:0] CMD_IN1 = 3'h1;
   localparam logic [2:0] CMD_OUT0 = 3'h2;
   localparam logic [2:0] CMD_OUT1 = 3'h3;
   localparam logic [2:0] CMD_POL0 = 3'h4;
   localparam logic [2:0] CMD_POL1 = 3'h5;
   localparam logic [2:0] CMD_CFG0 = 3'h6;
   localparam logic [2:0] CMD_CFG1 = 3'h7;
   localparam logic [7:0] OUT_RESET = 8'hff;
   localparam logic [7:0] POL_RESET = 8'h00;
   localparam logic [7:0] CFG_RESET = 8'hff;
   localparam logic [7:0] CMD_RESET = 8'h00;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
endpackage

// File: sync2.sv
// Purpose: Two-flop synchroniser for a bundle of pin inputs
// Assumes: Inputs are asynchronous to clk_in
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '1
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   // Two stages, reset to idle level
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         s1_q <= INIT;
         s2_q <= INIT;
      end else begin
         s1_q <= d_in;
         s2_q <= s1_q;
      end
   end
   assign q_out = s2_q;
endmodule

// File: serial_io_expander_core.sv
// Purpose: Digital core of a 16-line I/O expander on a two-wire serial bus
// Assumes: scl/sda oversampled by ref_clk_in; open-drain pins split into in/oe
// Notes: Port lines, serial pins and address pin pass two flops first
`timescale 1ns/1ps
module serial_io_expander_core
   import ioexp_pkg::*;
#(
   parameter int LINES = 2 * PORT_W
) (
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_oe_out,
   input wire logic addr_sel_in,
   input wire logic [PORT_W-1:0] port0_lines_in,
   input wire logic [PORT_W-1:0] port1_lines_in,
   output logic [PORT_W-1:0] port0_lines_out,
   output logic [PORT_W-1:0] port1_lines_out,
   output logic [PORT_W-1:0] port0_lines_oe_out,
   output logic [PORT_W-1:0] port1_lines_oe_out,
   output logic [LINES-1:0] high_side_driver_out,
   output logic [LINES-1:0] low_side_driver_out,
   output logic int_oe_out
);
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA, ST_IGNORE} bus_state_t;

   // Synchronised pins
   logic [LINES+2:0] raw_all;
   logic [LINES+2:0] syn_all;
   logic [LINES-1:0] pins_s;
   logic scl_s;
   logic sda_s;
   logic addr_s;
   assign raw_all = {addr_sel_in, scl_in, sda_in, port1_lines_in, port0_lines_in};

   // Bus pins idle high; port lines idle at the input register's reset value, so no false change
   sync2 #(.W(LINES + 3), .INIT({3'b111, {LINES{1'b0}}})) u_sync (
      .clk_in(ref_clk_in),
      .nrst_in(nrst_in),
      .d_in(raw_all),
      .q_out(syn_all)
   );
   assign pins_s = syn_all[LINES-1:0];
   assign sda_s = syn_all[LINES];
   assign scl_s = syn_all[LINES+1];
   assign addr_s = syn_all[LINES+2];

   // Register state: input, output, polarity and direction, one byte per port
   logic [LINES-1:0] in_q, in_d;
   logic [LINES-1:0] out_q, out_d;
   logic [LINES-1:0] pol_q, pol_d;
   logic [LINES-1:0] cfg_q, cfg_d;
   logic [7:0] cmd_q, cmd_d;
   // Bus state
   bus_state_t st_q, st_d;
   logic scl_prev_q, sda_prev_q;
   logic [3:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d;
   logic rw_q, rw_d;
   logic sda_oe_q, sda_oe_d;
   logic int_q, int_d;
   logic [LINES-1:0] diff_c;

   logic scl_rise, scl_fall, start_c, stop_c;
   assign scl_rise = scl_s & ~scl_prev_q;
   assign scl_fall = ~scl_s & scl_prev_q;
   assign start_c = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   assign stop_c = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

   // Readback of selected register
   function automatic logic [7:0] reg_rd(input logic [2:0] sel, input logic [LINES-1:0] inr,
         input logic [LINES-1:0] outr, input logic [LINES-1:0] polr, input logic [LINES-1:0] cfgr);
      logic [LINES-1:0] v;
      v = '0;
      case (sel)
         CMD_IN0, CMD_IN1: v = inr ^ polr;
         CMD_OUT0, CMD_OUT1: v = outr;
         CMD_POL0, CMD_POL1: v = polr;
         default: v = cfgr;
      endcase
      reg_rd = sel[0] ? v[LINES-1:PORT_W] : v[PORT_W-1:0];
   endfunction

   // Bus protocol and register writes
   always_comb begin
      st_d = st_q;
      bit_d = bit_q;
      sh_d = sh_q;
      rw_d = rw_q;
      sda_oe_d = sda_oe_q;
      cmd_d = cmd_q;
      out_d = out_q;
      pol_d = pol_q;
      cfg_d = cfg_q;
      in_d = in_q;
      if (start_c) begin
         st_d = ST_ADDR;
         bit_d = 4'h0;
         sda_oe_d = 1'b0;
      end else if (stop_c) begin
         st_d = ST_IDLE;
         sda_oe_d = 1'b0;
      end else if (st_q != ST_IDLE && st_q != ST_IGNORE) begin
         if (scl_rise) begin
            if (bit_q <= BIT_LAST) begin
               sh_d = {sh_q[6:0], sda_s};
               bit_d = bit_q + 4'h1;
            end else if (st_q == ST_RDATA && bit_q == BIT_ACK) begin
               // Ack or nack of a read byte: reload port input register
               if (cmd_q[2:0] == CMD_IN0) begin
                  in_d[PORT_W-1:0] = pins_s[PORT_W-1:0];
               end
               if (cmd_q[2:0] == CMD_IN1) begin
                  in_d[LINES-1:PORT_W] = pins_s[LINES-1:PORT_W];
               end
               bit_d = BIT_ACK + 4'h1; // Ack slot seen high
               if (sda_s) begin
                  st_d = ST_IGNORE; // Nack ends the read
               end
            end
         end else if (scl_fall) begin
            if (st_q == ST_RDATA) begin
               // Read byte: shift bits out, free the line for the ack, then load the next byte
               if (bit_q == BIT_ACK) begin
                  sda_oe_d = 1'b0; // Controller owns the ack slot
               end else if (bit_q > BIT_ACK) begin
                  bit_d = 4'h0;
                  cmd_d = {cmd_q[7:1], ~cmd_q[0]}; // Alternate within register pair
                  sh_d = reg_rd(cmd_d[2:0], pins_s, out_q, pol_q, cfg_q);
                  sda_oe_d = ~sh_d[7];
               end else begin
                  sda_oe_d = ~sh_q[7]; // Next read bit
               end
            end else if (bit_q == BIT_ACK && sda_oe_q == 1'b0) begin
               // Byte received: act on it and acknowledge, except an address for another target
               case (st_q)
                  ST_ADDR: begin
                     if (sh_q[7:1] == {TARGET_BASE[6:1], addr_s}) begin
                        rw_d = sh_q[0];
                        sda_oe_d = 1'b1;
                     end else begin
                        st_d = ST_IGNORE;
                     end
                  end
                  ST_CMD: begin
                     cmd_d = sh_q;
                     sda_oe_d = 1'b1;
                  end
                  default: begin
                     sda_oe_d = 1'b1;
                     case (cmd_q[2:0])
                        CMD_OUT0: out_d[PORT_W-1:0] = sh_q;
                        CMD_OUT1: out_d[LINES-1:PORT_W] = sh_q;
                        CMD_POL0: pol_d[PORT_W-1:0] = sh_q;
                        CMD_POL1: pol_d[LINES-1:PORT_W] = sh_q;
                        CMD_CFG0: cfg_d[PORT_W-1:0] = sh_q;
                        CMD_CFG1: cfg_d[LINES-1:PORT_W] = sh_q;
                        default: ; // Input registers are read only
                     endcase
                     cmd_d = {cmd_q[7:1], ~cmd_q[0]}; // Alternate within register pair
                  end
               endcase
            end else if (bit_q == BIT_ACK) begin
               // End of ack slot: start next byte
               bit_d = 4'h0;
               sda_oe_d = 1'b0;
               if (st_q == ST_ADDR) begin
                  st_d = rw_q ? ST_RDATA : ST_CMD;
               end else if (st_q == ST_CMD) begin
                  st_d = ST_WDATA;
               end
               // First read byte: live pin levels for input ports, so a read never reports stale data
               if (st_d == ST_RDATA) begin
                  sh_d = reg_rd(cmd_q[2:0], pins_s, out_q, pol_q, cfg_q);
                  sda_oe_d = ~sh_d[7];
               end
            end
         end
      end
   end

   // Input compare and interrupt; output lines are masked off
   always_comb begin
      diff_c = (pins_s ^ in_q) & cfg_q;
      int_d = |diff_c;
   end

   // Bus state registers
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         st_q <= ST_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         rw_q <= 1'b0;
         sda_oe_q <= 1'b0;
         cmd_q <= CMD_RESET;
      end else begin
         st_q <= st_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         rw_q <= rw_d;
         sda_oe_q <= sda_oe_d;
         cmd_q <= cmd_d;
      end
   end

   // Register file; the input registers start at zero
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         out_q <= {2{OUT_RESET}};
         pol_q <= {2{POL_RESET}};
         cfg_q <= {2{CFG_RESET}};
         in_q <= '0;
      end else begin
         out_q <= out_d;
         pol_q <= pol_d;
         cfg_q <= cfg_d;
         in_q <= in_d;
      end
   end

   // Interrupt flop and bus pin history for edge detection
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         int_q <= 1'b0;
         scl_prev_q <= 1'b1; // Idle bus level, so no false edge after reset
         sda_prev_q <= 1'b1;
      end else begin
         int_q <= int_d;
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
      end
   end

   // Pin drivers: input lines float, output lines drive per output bit
   always_comb begin
      high_side_driver_out = ~cfg_q & out_q;
      low_side_driver_out = ~cfg_q & ~out_q;
      port0_lines_out = out_q[PORT_W-1:0];
      port1_lines_out = out_q[LINES-1:PORT_W];
      port0_lines_oe_out = ~cfg_q[PORT_W-1:0];
      port1_lines_oe_out = ~cfg_q[LINES-1:PORT_W];
   end

   assign sda_oe_out = sda_oe_q;
   assign int_oe_out = int_q;
endmodule

// File: ioexp_sva.sv
// Purpose: Port-level checks of the expander core
// Assumes: Synchronous active-low reset on ref_clk_in
// Notes: A quiet counter tells bus or pin activity from idle
`timescale 1ns/1ps
module ioexp_sva
   import ioexp_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_oe_out,
   input wire logic [PORT_W-1:0] port0_lines_in,
   input wire logic [PORT_W-1:0] port1_lines_in,
   input wire logic [PORT_W-1:0] port0_lines_out,
   input wire logic [PORT_W-1:0] port1_lines_out,
   input wire logic [PORT_W-1:0] port0_lines_oe_out,
   input wire logic [PORT_W-1:0] port1_lines_oe_out,
   input wire logic [2*PORT_W-1:0] high_side_driver_out,
   input wire logic [2*PORT_W-1:0] low_side_driver_out,
   input wire logic int_oe_out
);
   logic [2*PORT_W+1:0] seen_d, seen_q;
   logic [4:0] quiet_d, quiet_q;
   wire logic [2*PORT_W-1:0] oe_w = {port1_lines_oe_out, port0_lines_oe_out};
   wire logic [2*PORT_W-1:0] out_w = {port1_lines_out, port0_lines_out};
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);
   // Cycles since the last edge on the bus or a pin
   always_comb begin
      seen_d = {scl_in, sda_in, port1_lines_in, port0_lines_in};
      quiet_d = (!nrst_in || seen_d != seen_q) ? 5'h00 : quiet_q + {4'h0, quiet_q != 5'h1f};
   end
   always_ff @(posedge ref_clk_in) begin
      seen_q <= seen_d;
      quiet_q <= quiet_d;
   end
   property p_in_idle; ((high_side_driver_out | low_side_driver_out) & ~oe_w) == '0; endproperty
   a_in_idle: assert property (p_in_idle) else $error("input line driven");
   property p_hi; high_side_driver_out == (oe_w & out_w); endproperty
   a_hi: assert property (p_hi) else $error("high side wrong");
   property p_lo; low_side_driver_out == (oe_w & ~out_w); endproperty
   a_lo: assert property (p_lo) else $error("low side wrong");
   property p_rst; $rose(nrst_in) |-> oe_w == '0 && out_w == '1 && !int_oe_out && !sda_oe_out; endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   property p_int_quiet; quiet_q > 5'h0c |-> $stable(int_oe_out); endproperty
   a_int_quiet: assert property (p_int_quiet) else $error("interrupt moved when idle");
   property p_cfg_quiet; quiet_q > 5'h0c |-> $stable(oe_w); endproperty
   a_cfg_quiet: assert property (p_cfg_quiet) else $error("direction moved when idle");
   property p_out_quiet; quiet_q > 5'h0c |-> $stable(out_w); endproperty
   a_out_quiet: assert property (p_out_quiet) else $error("output moved when idle");
   property p_sda_idle; quiet_q > 5'h0c |-> !sda_oe_out; endproperty
   a_sda_idle: assert property (p_sda_idle) else $error("data line held when idle");
endmodule
bind serial_io_expander_core ioexp_sva u_sva (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
   .scl_in(scl_in), .sda_in(sda_in), .sda_oe_out(sda_oe_out),
   .port0_lines_in(port0_lines_in), .port1_lines_in(port1_lines_in),
   .port0_lines_out(port0_lines_out), .port1_lines_out(port1_lines_out),
   .port0_lines_oe_out(port0_lines_oe_out), .port1_lines_oe_out(port1_lines_oe_out),
   .high_side_driver_out(high_side_driver_out), .low_side_driver_out(low_side_driver_out),
   .int_oe_out(int_oe_out));

// File: ioexp_host.sv
// Purpose: Two-wire bus controller model
// Assumes: Pulled-up data line, level seen on sda_in
// Notes: Clock half periods of four ref clocks, still when idle
`timescale 1ns/1ps
module ioexp_host (
   input wire logic ref_clk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_pull_out
);
   initial begin
      scl_out = 1'b1;
      sda_pull_out = 1'b0;
   end
   // One bit: data moves a clock after scl fell, then scl high
   task automatic bitw(input logic pull);
      @(negedge ref_clk_in);
      sda_pull_out = pull;
      repeat (3) @(negedge ref_clk_in);
      scl_out = 1'b1;
      repeat (4) @(negedge ref_clk_in);
   endtask
   task automatic start();
      bitw(1'b0);
      sda_pull_out = 1'b1;
      repeat (4) @(negedge ref_clk_in);
      scl_out = 1'b0;
   endtask
   task automatic stop();
      bitw(1'b1);
      sda_pull_out = 1'b0;
      repeat (4) @(negedge ref_clk_in);
   endtask
   // Byte MSB first, then acknowledge slot
   task automatic xfer(input logic [7:0] tx, input logic ack_pull, output logic [7:0] rx,
      output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bitw(~tx[i]);
         rx[i] = sda_in;
         scl_out = 1'b0;
      end
      bitw(ack_pull);
      ack = ~sda_in;
      scl_out = 1'b0;
   endtask
endmodule

// File: serial_io_expander_core_tb.sv
// Purpose: Self-checking bench of the expander core
// Assumes: Inputs change on the falling clock edge
// Notes: Pins of output lines follow the design's drive
`timescale 1ns/1ps
module serial_io_expander_core_tb
   import ioexp_pkg::*;
;
   logic clk = 1'b0, nrst = 1'b0, sel = 1'b0, sda_oe, int_oe, scl, pull, ak;
   logic [7:0] ext0 = 8'h00, ext1 = 8'h00, o0, o1, e0, e1, rx;
   logic [15:0] hi, lo;
   int checks = 0, failures = 0;
   wire logic sda = ~(pull | sda_oe);
   wire logic [7:0] pin0 = (e0 & o0) | (~e0 & ext0);
   wire logic [7:0] pin1 = (e1 & o1) | (~e1 & ext1);
   initial forever #5 clk = ~clk;
   serial_io_expander_core u_dut (.ref_clk_in(clk), .nrst_in(nrst), .scl_in(scl), .sda_in(sda),
      .sda_oe_out(sda_oe), .addr_sel_in(sel), .port0_lines_in(pin0), .port1_lines_in(pin1),
      .port0_lines_out(o0), .port1_lines_out(o1), .port0_lines_oe_out(e0), .port1_lines_oe_out(e1),
      .high_side_driver_out(hi), .low_side_driver_out(lo), .int_oe_out(int_oe));
   ioexp_host u_host (.ref_clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_pull_out(pull));
   task automatic test_done();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [7:0] adr(input logic rd);
      return {TARGET_BASE[6:1], sel, rd};
   endfunction
   task automatic send(input logic [7:0] b);
      u_host.xfer(b, 1'b0, rx, ak);
      chk("ack", ak, 1'b1);
   endtask
   task automatic wr(input logic [2:0] c, input logic [7:0] d);
      u_host.start();
      send(adr(1'b0));
      send({5'h00, c});
      send(d);
      u_host.stop();
   endtask
   task automatic rd(input logic [2:0] c);
      u_host.start();
      send(adr(1'b0));
      send({5'h00, c});
      u_host.start();
      send(adr(1'b1));
      u_host.xfer(8'hff, 1'b0, rx, ak);
      u_host.stop();
   endtask
   task automatic wait_int(input logic v);
      for (int n = 0; n < 40 && int_oe !== v; n++) @(negedge clk);
      chk("int", int_oe, v);
      if (int_oe !== v) test_done();
   endtask
   task automatic t_defaults();
      chk("oe", {e1, e0}, 16'h0000);
      chk("drive", hi | lo, 16'h0000);
      chk("outs", {o1, o0}, 16'hffff);
      for (int c = 0; c < 8; c++) begin
         rd(c[2:0]);
         chk("reg", rx, (c[2:1] == 2'h1) ? OUT_RESET : (c[2:1] == 2'h2) ? POL_RESET :
            (c[2:1] == 2'h3) ? CFG_RESET : 8'h00);
      end
      chk("int", int_oe, 1'b0);
   endtask
   task automatic t_output();
      wr(CMD_CFG0, 8'hf0);
      wr(CMD_OUT0, 8'ha5);
      chk("oe", {e1, e0}, 16'h000f);
      chk("hi", hi, 16'h0005);
      chk("lo", lo, 16'h000a);
      rd(CMD_OUT0);
      chk("out0", rx, 8'ha5);
      wr(CMD_OUT0, 8'h5a);
      chk("int", int_oe, 1'b0);
      ext0 = 8'h02;
      wr(CMD_CFG0, 8'hff);
      wait_int(1'b1);
      rd(CMD_IN0);
      chk("in0", {rx, 7'h0, int_oe}, 16'h0200);
   endtask
   task automatic t_int();
      ext1 = 8'h08;
      wait_int(1'b1);
      ext1 = 8'h00;
      wait_int(1'b0);
      ext1 = 8'h08;
      wait_int(1'b1);
      rd(CMD_IN1);
      chk("in1", {rx, 7'h0, int_oe}, 16'h0800);
      ext1 = 8'h00;
      wait_int(1'b1);
      u_host.start();
      u_host.xfer({TARGET_BASE[6:1], ~sel, 1'b1}, 1'b0, rx, ak);
      u_host.stop();
      chk("other", {ak, int_oe}, 2'b01);
      sel = 1'b1;
      rd(CMD_IN1);
      chk("sel", int_oe, 1'b0);
      wr(CMD_POL1, 8'hff);
      rd(CMD_IN1);
      chk("pol", rx, 8'hff);
   endtask
   task automatic t_reset();
      wr(CMD_OUT1, 8'h3c);
      wr(CMD_CFG1, 8'h00);
      chk("set", {e1, o1}, 16'hff3c);
      u_host.start();
      send(adr(1'b0));
      nrst = 1'b0;
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      chk("rst", {e1, o1}, 16'h00ff);
      u_host.stop();
      rd(CMD_POL1);
      chk("pol1", rx, 8'h00);
   endtask
   initial begin
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      t_defaults();
      t_output();
      t_int();
      t_reset();
      test_done();
   end
endmodule
